/* bpca_core.sv */
// priority split registers and control register access with trap decode
// Function
// - group-1 split field divides 8-bit priority into group and subpriority
// - secure value n: group bits 7..n+1; value 7 gives no preemption
// - non-secure value n: group bits 7..n; zero has no split
// - writing zero to the group-1 split loads its non-zero reset value
// - with level 3 and secure shared select, secure L1 writes hit group-0
// - same condition, secure L1 reads return the group-0 split
// - non-secure shared select, no routing or trap: reads give group-0+1 sat
// - same case: non-secure L1 and L2 writes are ignored
// - non-secure shared select, irq trap, no routing: L1/L2 trap to level 3
// - shared select with routing: L1 goes virtual, L2 sat read, write ignored
// - routing and irq trap both set: non-secure L2 traps to level 3
// - no level 3: control shared bit selects same behaviour by routing bit
// - core reaches group-1 split with encoding 11 000 1100 1100 011
// - routing bit set: non-secure L1 group-1 access goes to virtual copy
// - secure control copy from secure L1/L3; non-secure from NS L1/L2/L3
// - NS L1 control access is physical only when both routing bits clear
// - control access from level 1, 2 or 3 traps there if its enable is 0
// - common register trap bit set: NS L1 control access traps to level 2
// - both top trap bits set: secure L1 control access traps to level 3
// - both top trap bits set: level-2 control access traps to level 3
// - both top traps, both routing clear: NS L1 control traps to level 3
// - control register is 32 bits with secure and non-secure copies
// - shared select makes group-0 split set group-1 preemption grouping
`timescale 1ns/1ps
`default_nettype none
module bpca_core #(
  parameter logic [2:0] SPLIT0_MIN = bpca_pkg::SPLIT0_MIN_RST,
  parameter logic [2:0] SPLIT1_S_RESET = bpca_pkg::SPLIT1_S_RST,
  parameter logic [2:0] SPLIT1_NS_RESET = bpca_pkg::SPLIT1_NS_RST
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_op0,
  input  wire logic [2:0]  acc_op1,
  input  wire logic [3:0]  acc_crn,
  input  wire logic [3:0]  acc_crm,
  input  wire logic [2:0]  acc_op2,
  input  wire logic [1:0]  acc_level,
  input  wire logic        acc_secure,
  input  wire logic [31:0] acc_wdata,
  input  wire logic        lvl3_present,
  input  wire logic        hyp_irq_route,
  input  wire logic        hyp_fiq_route,
  input  wire logic        top_irq_trap,
  input  wire logic        top_fiq_trap,
  input  wire logic        lvl1_sysreg_enable,
  input  wire logic        lvl2_sysreg_enable,
  input  wire logic        lvl3_sysreg_enable,
  input  wire logic        hyp_common_reg_trap,
  input  wire logic        secure_shared_split_select,
  input  wire logic        nonsecure_shared_split_select,
  output logic             resp_valid,
  output logic [31:0]      resp_rdata,
  output logic             resp_trap,
  output logic [1:0]       resp_trap_level,
  output logic             resp_virtual,
  output logic [2:0]       g0_split,
  output logic [2:0]       g1_split_s,
  output logic [2:0]       g1_split_ns,
  output logic [7:0]       g1_group_mask_s,
  output logic [7:0]       g1_group_mask_ns
);

  // group priority bits kept above the cut; cut 8 means no preemption
  function automatic logic [7:0] grp_mask(input logic [3:0] cut);
    grp_mask = (cut >= 4'h8) ? 8'h00 : 8'(8'hFF << cut);
  endfunction : grp_mask

  // zero loads the reset value, below minimum clamps to the minimum
  function automatic logic [2:0] fix_split(input logic [2:0] v,
                                           input logic [2:0] minv,
                                           input logic [2:0] rstv);
    if (v == 3'h0) begin
      fix_split = rstv;
    end else if (v < minv) begin
      fix_split = minv;
    end else begin
      fix_split = v;
    end
  endfunction : fix_split

  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    sat_inc = (v == bpca_pkg::SPLIT_MAX) ? bpca_pkg::SPLIT_MAX : v + 3'h1;
  endfunction : sat_inc

  logic [2:0]  g0_r, g0_nxt;
  logic [2:0]  g1s_r, g1s_nxt;
  logic [2:0]  g1ns_r, g1ns_nxt;
  logic [31:0] ctl_s_r, ctl_s_nxt;
  logic [31:0] ctl_ns_r, ctl_ns_nxt;
  logic        rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        tr_r, tr_nxt;
  logic [1:0]  tl_r, tl_nxt;
  logic        vi_r, vi_nxt;
  logic [7:0]  ms_r, ms_nxt;
  logic [7:0]  mns_r, mns_nxt;

  logic        enc_base;
  logic        hit_g1;
  logic        hit_g0;
  logic        hit_ctl;
  logic        is_ns;
  logic        sre_ok;
  logic        ns_shared;
  logic        both_top;
  logic        no_route;
  logic        s_shared_eff;

  always_comb begin
    enc_base  = acc_op0 == bpca_pkg::ENC_OP0 && acc_op1 == bpca_pkg::ENC_OP1
             && acc_crn == bpca_pkg::ENC_CRN;
    hit_g1    = enc_base && acc_crm == bpca_pkg::ENC_CRM_G1
             && acc_op2 == bpca_pkg::ENC_OP2_G1;
    hit_g0    = enc_base && acc_crm == bpca_pkg::ENC_CRM_G0
             && acc_op2 == bpca_pkg::ENC_OP2_G0;
    hit_ctl   = enc_base && acc_crm == bpca_pkg::ENC_CRM_CTL
             && acc_op2 == bpca_pkg::ENC_OP2_CTL;
    is_ns     = !acc_secure || acc_level == bpca_pkg::LVL_2;
    sre_ok    = (acc_level == bpca_pkg::LVL_1 && lvl1_sysreg_enable)
             || (acc_level == bpca_pkg::LVL_2 && lvl2_sysreg_enable)
             || (acc_level == bpca_pkg::LVL_3 && lvl3_sysreg_enable);
    // without level 3 the non-secure control copy holds the shared bit
    ns_shared = lvl3_present ? nonsecure_shared_split_select
                             : ctl_ns_r[bpca_pkg::SHARED_BIT];
    s_shared_eff = lvl3_present && secure_shared_split_select;
    both_top  = lvl3_present && top_irq_trap && top_fiq_trap;
    no_route  = !hyp_irq_route && !hyp_fiq_route;

    g0_nxt   = g0_r;
    g1s_nxt  = g1s_r;
    g1ns_nxt = g1ns_r;
    ctl_s_nxt  = ctl_s_r;
    ctl_ns_nxt = ctl_ns_r;
    rv_nxt = acc_valid;
    rd_nxt = 32'h0000_0000;
    tr_nxt = 1'b0;
    tl_nxt = 2'h0;
    vi_nxt = 1'b0;

    if (acc_valid && !sre_ok && (hit_g1 || hit_g0 || hit_ctl)) begin
      tr_nxt = 1'b1;
      tl_nxt = acc_level;
    end else if (acc_valid && hit_ctl) begin
      if (is_ns && acc_level == bpca_pkg::LVL_1 && hyp_common_reg_trap) begin
        tr_nxt = 1'b1;
        tl_nxt = bpca_pkg::LVL_2;
      end else if (both_top && (acc_level == bpca_pkg::LVL_2
               || (acc_level == bpca_pkg::LVL_1 && !is_ns)
               || (acc_level == bpca_pkg::LVL_1 && no_route))) begin
        tr_nxt = 1'b1;
        tl_nxt = bpca_pkg::LVL_3;
      end else if (is_ns && acc_level == bpca_pkg::LVL_1 && !no_route) begin
        vi_nxt = 1'b1;
      end else if (is_ns) begin
        rd_nxt = ctl_ns_r;
        if (lvl3_present) begin
          rd_nxt[bpca_pkg::SHARED_BIT] = nonsecure_shared_split_select;
        end
        if (acc_write) begin
          ctl_ns_nxt = acc_wdata;
        end
      end else begin
        rd_nxt = ctl_s_r;
        rd_nxt[bpca_pkg::SHARED_BIT] = secure_shared_split_select;
        if (acc_write) begin
          ctl_s_nxt = acc_wdata;
        end
      end
    end else if (acc_valid && hit_g0) begin
      if (is_ns && acc_level == bpca_pkg::LVL_1 && hyp_fiq_route) begin
        vi_nxt = 1'b1;
      end else begin
        rd_nxt = {29'h0, g0_r};
        if (acc_write) begin
          g0_nxt = fix_split(acc_wdata[bpca_pkg::SPLIT_MSB:0], SPLIT0_MIN,
                             SPLIT0_MIN);
        end
      end
    end else if (acc_valid && hit_g1) begin
      if (lvl3_present && top_irq_trap && (acc_level == bpca_pkg::LVL_2
          || (acc_level == bpca_pkg::LVL_1 && !is_ns)
          || (acc_level == bpca_pkg::LVL_1 && !hyp_irq_route))) begin
        tr_nxt = 1'b1;
        tl_nxt = bpca_pkg::LVL_3;
      end else if (is_ns && acc_level == bpca_pkg::LVL_1
                   && hyp_irq_route) begin
        vi_nxt = 1'b1;
      end else if (!is_ns && acc_level == bpca_pkg::LVL_1 && s_shared_eff) begin
        rd_nxt = {29'h0, g0_r};
        if (acc_write) begin
          g0_nxt = fix_split(acc_wdata[bpca_pkg::SPLIT_MSB:0], SPLIT0_MIN,
                             SPLIT0_MIN);
        end
      end else if (is_ns && acc_level != bpca_pkg::LVL_3 && ns_shared) begin
        rd_nxt = {29'h0, sat_inc(g0_r)};
      end else if (is_ns) begin
        rd_nxt = {29'h0, g1ns_r};
        if (acc_write) begin
          g1ns_nxt = fix_split(acc_wdata[bpca_pkg::SPLIT_MSB:0],
                               SPLIT0_MIN + 3'h1, SPLIT1_NS_RESET);
        end
      end else begin
        rd_nxt = {29'h0, g1s_r};
        if (acc_write) begin
          g1s_nxt = fix_split(acc_wdata[bpca_pkg::SPLIT_MSB:0], SPLIT0_MIN,
                              SPLIT1_S_RESET);
        end
      end
    end

    // group-1 preemption masks follow group-0 when sharing is on
    ms_nxt  = s_shared_eff ? grp_mask({1'b0, g0_r} + 4'h1)
                           : grp_mask({1'b0, g1s_r} + 4'h1);
    mns_nxt = ns_shared ? grp_mask({1'b0, g0_r} + 4'h1)
                        : grp_mask({1'b0, g1ns_r});
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      g0_r     <= SPLIT0_MIN;
      g1s_r    <= SPLIT1_S_RESET;
      g1ns_r   <= SPLIT1_NS_RESET;
      ctl_s_r  <= bpca_pkg::CTL_RST;
      ctl_ns_r <= bpca_pkg::CTL_RST;
      rv_r     <= 1'b0;
      rd_r     <= 32'h0000_0000;
      tr_r     <= 1'b0;
      tl_r     <= 2'h0;
      vi_r     <= 1'b0;
      ms_r     <= 8'h00;
      mns_r    <= 8'h00;
    end else begin
      g0_r     <= g0_nxt;
      g1s_r    <= g1s_nxt;
      g1ns_r   <= g1ns_nxt;
      ctl_s_r  <= ctl_s_nxt;
      ctl_ns_r <= ctl_ns_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      tr_r     <= tr_nxt;
      tl_r     <= tl_nxt;
      vi_r     <= vi_nxt;
      ms_r     <= ms_nxt;
      mns_r    <= mns_nxt;
    end
  end

  assign resp_valid       = rv_r;
  assign resp_rdata       = rd_r;
  assign resp_trap        = tr_r;
  assign resp_trap_level  = tl_r;
  assign resp_virtual     = vi_r;
  assign g0_split         = g0_r;
  assign g1_split_s       = g1s_r;
  assign g1_split_ns      = g1ns_r;
  assign g1_group_mask_s  = ms_r;
  assign g1_group_mask_ns = mns_r;

  // checks
  sre_trap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && hit_ctl && acc_level == bpca_pkg::LVL_2 && !lvl2_sysreg_enable
    |=> resp_trap && resp_trap_level == bpca_pkg::LVL_2)
    else $error("disabled level 2 access did not trap to level 2");

  common_trap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && hit_ctl && sre_ok && !acc_secure
    && acc_level == bpca_pkg::LVL_1 && hyp_common_reg_trap
    |=> resp_trap && resp_trap_level == bpca_pkg::LVL_2)
    else $error("common register trap not taken to level 2");

  top_trap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && hit_ctl && lvl2_sysreg_enable && lvl3_present
    && acc_level == bpca_pkg::LVL_2 && top_irq_trap && top_fiq_trap
    |=> resp_trap && resp_trap_level == bpca_pkg::LVL_3)
    else $error("level 2 control access not trapped to level 3");

  ctl_virt_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && hit_ctl && sre_ok && !acc_secure && !hyp_common_reg_trap
    && acc_level == bpca_pkg::LVL_1 && !no_route && !both_top
    |=> resp_virtual && !resp_trap)
    else $error("routed control access not sent to virtual copy");

  zero_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && acc_write && hit_g1 && sre_ok && acc_secure
    && acc_level == bpca_pkg::LVL_3 && acc_wdata[2:0] == 3'h0
    |=> g1_split_s == SPLIT1_S_RESET)
    else $error("zero write did not load reset value");

  sat_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && !acc_write && hit_g1 && sre_ok && !acc_secure
    && acc_level == bpca_pkg::LVL_1 && lvl3_present && !top_irq_trap
    && !hyp_irq_route && nonsecure_shared_split_select
    |=> resp_rdata == {29'h0, sat_inc($past(g0_r))})
    else $error("shared read did not return saturated group-0 plus one");

  ignore_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && acc_write && hit_g1 && sre_ok && !acc_secure
    && acc_level == bpca_pkg::LVL_2 && ns_shared
    |=> $stable(g1_split_ns))
    else $error("shared-mode write changed the group-1 split");

  alias_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid && acc_write && hit_g1 && sre_ok && acc_secure
    && acc_level == bpca_pkg::LVL_1 && s_shared_eff && !top_irq_trap
    && acc_wdata[2:0] >= SPLIT0_MIN
    |=> g0_split == $past(acc_wdata[2:0]) && $stable(g1_split_s))
    else $error("secure shared write did not reach group-0");

  mask_ns_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ns_shared ##1 !ns_shared && $stable(g1_split_ns)
    |=> g1_group_mask_ns == 8'(8'hFF << $past(g1_split_ns)))
    else $error("non-secure group mask wrong for split value");

  resp_lat_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    acc_valid |=> resp_valid)
    else $error("access got no response one cycle later");

endmodule : bpca_core
`default_nettype wire

/* bpca_core_model.sv */
// core model that issues system register accesses and collects answers
`timescale 1ns/1ps
`default_nettype none
module bpca_core_model (
  input  wire logic        ref_clk,
  output logic             acc_valid,
  output logic             acc_write,
  output logic [1:0]       acc_op0,
  output logic [2:0]       acc_op1,
  output logic [3:0]       acc_crn,
  output logic [3:0]       acc_crm,
  output logic [2:0]       acc_op2,
  output logic [1:0]       acc_level,
  output logic             acc_secure,
  output logic [31:0]      acc_wdata,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_rdata,
  input  wire logic        resp_trap,
  input  wire logic [1:0]  resp_trap_level,
  input  wire logic        resp_virtual
);
  initial begin
    acc_valid  = 1'b0;
    acc_write  = 1'b0;
    acc_op0    = bpca_pkg::ENC_OP0;
    acc_op1    = bpca_pkg::ENC_OP1;
    acc_crn    = bpca_pkg::ENC_CRN;
    acc_crm    = 4'h0;
    acc_op2    = 3'h0;
    acc_level  = 2'h1;
    acc_secure = 1'b0;
    acc_wdata  = 32'h0;
  end

  // one-cycle request pulse, answer collected after it drops
  task automatic access(input logic wr, input logic [3:0] crm,
                        input logic [2:0] op2, input logic [1:0] lvl,
                        input logic sec, input logic [31:0] wd,
                        output logic [31:0] rd, output logic [4:0] st);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    acc_valid  = 1'b1;
    acc_write  = wr;
    acc_crm    = crm;
    acc_op2    = op2;
    acc_level  = lvl;
    acc_secure = sec;
    acc_wdata  = wd;
    @(posedge ref_clk);
    #1;
    acc_valid = 1'b0;
    // released data lines do not keep the last value
    acc_wdata = ~wd;
    while (resp_valid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    rd = resp_rdata;
    st = {resp_valid === 1'b1, resp_trap, resp_trap_level, resp_virtual};
  endtask : access
endmodule : bpca_core_model
`default_nettype wire

/* bpca_pkg.sv */
// shared constants for the priority split and control access block
package bpca_pkg;
  // system register encoding fields
  localparam logic [1:0] ENC_OP0       = 2'h3;
  localparam logic [2:0] ENC_OP1       = 3'h0;
  localparam logic [3:0] ENC_CRN       = 4'hC;
  localparam logic [3:0] ENC_CRM_G1    = 4'hC;
  localparam logic [2:0] ENC_OP2_G1    = 3'h3;
  localparam logic [3:0] ENC_CRM_G0    = 4'h8;
  localparam logic [2:0] ENC_OP2_G0    = 3'h3;
  localparam logic [3:0] ENC_CRM_CTL   = 4'hC;
  localparam logic [2:0] ENC_OP2_CTL   = 3'h4;
  // privilege levels
  localparam logic [1:0] LVL_1         = 2'h1;
  localparam logic [1:0] LVL_2         = 2'h2;
  localparam logic [1:0] LVL_3         = 2'h3;
  // field layout
  localparam int         SPLIT_MSB     = 2;
  localparam int         SHARED_BIT    = 0;
  localparam logic [2:0] SPLIT_MAX     = 3'h7;
  // reset values
  localparam logic [2:0]  SPLIT0_MIN_RST = 3'h2;
  localparam logic [2:0]  SPLIT1_S_RST   = 3'h2;
  localparam logic [2:0]  SPLIT1_NS_RST  = 3'h3;
  localparam logic [31:0] CTL_RST        = 32'h0000_0000;
  // response latency in cycles from request to answer
  localparam int          RESP_LAT       = 1;
endpackage : bpca_pkg

/* tb_binary_point_ctrl_access.sv */
// self-checking bench for the priority split and control access block
`timescale 1ns/1ps
`default_nettype none
module tb_binary_point_ctrl_access;
  logic        ref_clk, rst_b, acc_valid, acc_write, acc_secure;
  logic [1:0]  acc_op0, acc_level, resp_trap_level;
  logic [2:0]  acc_op1, acc_op2, g0_split, g1_split_s, g1_split_ns;
  logic [3:0]  acc_crn, acc_crm;
  logic [31:0] acc_wdata, resp_rdata, rd;
  logic        lvl3_present, hyp_irq_route, hyp_fiq_route;
  logic        top_irq_trap, top_fiq_trap, hyp_common_reg_trap;
  logic        lvl1_sysreg_enable, lvl2_sysreg_enable, lvl3_sysreg_enable;
  logic        secure_shared_split_select, nonsecure_shared_split_select;
  logic        resp_valid, resp_trap, resp_virtual;
  logic [7:0]  g1_group_mask_s, g1_group_mask_ns;
  logic [4:0]  st;
  int          bad_count;
  int          checks_done;
  localparam logic [1:0] L1 = bpca_pkg::LVL_1;
  localparam logic [1:0] L2 = bpca_pkg::LVL_2;
  localparam logic [1:0] L3 = bpca_pkg::LVL_3;

  bpca_core bpca_core_inst (.*);
  bpca_core_model bpca_core_model_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [3:0] crm,
                     input logic [2:0] op2, input logic [1:0] lvl,
                     input logic sec, input logic [31:0] wd);
    bpca_core_model_inst.access(wr, crm, op2, lvl, sec, wd, rd, st);
    if (st[4] !== 1'b1) begin
      chk({31'h0, st[4]}, 32'h1);
      wrap_up();
    end
  endtask : acc

  task automatic g1(input logic wr, input logic [1:0] lvl,
                    input logic sec, input logic [31:0] wd);
    acc(wr, bpca_pkg::ENC_CRM_G1, bpca_pkg::ENC_OP2_G1, lvl, sec, wd);
  endtask : g1

  task automatic ctl(input logic wr, input logic [1:0] lvl,
                     input logic sec, input logic [31:0] wd);
    acc(wr, bpca_pkg::ENC_CRM_CTL, bpca_pkg::ENC_OP2_CTL, lvl, sec, wd);
  endtask : ctl

  task automatic t_split;
    logic [7:0] m;
    for (int n = 3; n < 8; n++) begin
      g1(1'b1, L1, 1'b0, 32'hFFFFFFF8 | n);
      g1(1'b0, L1, 1'b0, 32'h0);
      m = 8'hFF << n;
      chk(rd, 32'(n));
      chk(32'(g1_group_mask_ns), 32'(m));
    end
    for (int n = 2; n < 8; n++) begin
      g1(1'b1, L1, 1'b1, 32'hFFFFFFF8 | n);
      g1(1'b0, L1, 1'b1, 32'h0);
      m = 8'hFF << (n + 1);
      chk(rd, 32'(n));
      chk(32'(g1_group_mask_s), 32'(m));
    end
    g1(1'b1, L1, 1'b0, 32'h0);
    chk(32'(g1_split_ns), 32'h3);
    g1(1'b1, L3, 1'b1, 32'h0);
    chk(32'(g1_split_s), 32'(bpca_pkg::SPLIT1_S_RST));
  endtask : t_split

  task automatic t_shared;
    secure_shared_split_select = 1'b1;
    g1(1'b1, L1, 1'b1, 32'h4);
    chk(32'(g0_split), 32'h4);
    chk(32'(g1_split_s), 32'h2);
    g1(1'b0, L1, 1'b1, 32'h0);
    chk(rd, 32'h4);
    chk(32'(g1_group_mask_s), 32'hE0);
    secure_shared_split_select = 1'b0;
    nonsecure_shared_split_select = 1'b1;
    g1(1'b0, L1, 1'b0, 32'h0);
    chk(rd, 32'h5);
    g1(1'b1, L2, 1'b0, 32'h6);
    g1(1'b0, L2, 1'b0, 32'h0);
    chk(rd, 32'h5);
    chk(32'(g1_split_ns), 32'h3);
    chk(32'(g1_group_mask_ns), 32'hE0);
    acc(1'b1, bpca_pkg::ENC_CRM_G0, bpca_pkg::ENC_OP2_G0, L1, 1'b1, 32'h7);
    g1(1'b0, L1, 1'b0, 32'h0);
    chk(rd, 32'h7);
    top_irq_trap = 1'b1;
    g1(1'b0, L1, 1'b0, 32'h0);
    chk(32'(st[3:0]), 32'hE);
    hyp_irq_route = 1'b1;
    g1(1'b1, L1, 1'b0, 32'h5);
    chk(32'(st[3:0]), 32'h1);
    g1(1'b0, L2, 1'b0, 32'h0);
    chk(32'(st[3:0]), 32'hE);
    top_irq_trap = 1'b0;
    g1(1'b1, L2, 1'b0, 32'h5);
    g1(1'b0, L2, 1'b0, 32'h0);
    chk(rd, 32'h7);
    chk(32'(g1_split_ns), 32'h3);
    hyp_irq_route = 1'b0;
    nonsecure_shared_split_select = 1'b0;
    lvl3_present = 1'b0;
    acc(1'b1, bpca_pkg::ENC_CRM_G0, bpca_pkg::ENC_OP2_G0, L1, 1'b1, 32'h5);
    ctl(1'b1, L1, 1'b0, 32'h1);
    g1(1'b0, L2, 1'b0, 32'h0);
    chk(rd, 32'h6);
    hyp_irq_route = 1'b1;
    g1(1'b0, L1, 1'b0, 32'h0);
    chk(32'(st[3:0]), 32'h1);
    hyp_irq_route = 1'b0;
    ctl(1'b1, L1, 1'b0, 32'h0);
    lvl3_present = 1'b1;
  endtask : t_shared

  task automatic t_ctl;
    ctl(1'b1, L1, 1'b1, 32'hA5A5A5A4);
    ctl(1'b1, L2, 1'b0, 32'h3C3C0002);
    ctl(1'b0, L3, 1'b1, 32'h0);
    chk(rd, 32'hA5A5A5A4);
    ctl(1'b0, L1, 1'b0, 32'h0);
    chk(rd, 32'h3C3C0002);
    hyp_fiq_route = 1'b1;
    ctl(1'b0, L1, 1'b0, 32'h0);
    chk(32'(st[3:0]), 32'h1);
    hyp_fiq_route = 1'b0;
    acc(1'b0, 4'h0, 3'h0, L1, 1'b0, 32'h0);
    chk(rd | 32'(st[3:0]), 32'h0);
  endtask : t_ctl

  task automatic tcase(input logic [5:0] cf, input logic [1:0] lvl,
                       input logic sec, input logic [3:0] e);
    {lvl1_sysreg_enable, lvl2_sysreg_enable, lvl3_sysreg_enable,
     hyp_common_reg_trap, top_irq_trap, top_fiq_trap} = cf;
    ctl(1'b0, lvl, sec, 32'h0);
    chk(32'(st[3:0]), 32'(e));
  endtask : tcase

  initial begin
    bad_count = 0;
    checks_done = 0;
    rst_b = 1'b0;
    lvl3_present = 1'b1;
    {hyp_irq_route, hyp_fiq_route, top_irq_trap, top_fiq_trap} = 4'h0;
    {lvl1_sysreg_enable, lvl2_sysreg_enable, lvl3_sysreg_enable} = 3'h7;
    hyp_common_reg_trap = 1'b0;
    secure_shared_split_select = 1'b0;
    nonsecure_shared_split_select = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'({g0_split, g1_split_s, g1_split_ns}), 32'h093);
    chk(32'({g1_group_mask_s, g1_group_mask_ns}), 32'hF8F8);
    t_split();
    t_shared();
    t_ctl();
    tcase(6'h18, L1, 1'b1, 4'hA);
    tcase(6'h28, L2, 1'b0, 4'hC);
    tcase(6'h30, L3, 1'b1, 4'hE);
    tcase(6'h3C, L1, 1'b0, 4'hC);
    tcase(6'h3B, L1, 1'b1, 4'hE);
    tcase(6'h3A, L1, 1'b1, 4'h0);
    tcase(6'h3B, L2, 1'b0, 4'hE);
    tcase(6'h3B, L1, 1'b0, 4'hE);
    tcase(6'h1B, L1, 1'b1, 4'hA);
    tcase(6'h38, L3, 1'b1, 4'h0);
    wrap_up();
  end
endmodule : tb_binary_point_ctrl_access
`default_nettype wire
